//--- pkg/disk_status_pkg.sv
// disk_status_pkg: layouts, encodings and counts shared by the status block.
// assumes a single board clock; disk engines deliver result fields as structs.
package disk_status_pkg;

  // result block length and byte index width
  localparam int unsigned RESULT_BYTES = 7;
  localparam int unsigned IDX_W        = 3;
  localparam logic [IDX_W-1:0] IDX_FIRST = 3'h0;
  localparam logic [IDX_W-1:0] IDX_LAST  = 3'h6;

  // termination classes carried in status zero bits 7:6
  localparam logic [1:0] TERM_NORMAL  = 2'h0;
  localparam logic [1:0] TERM_FAILED  = 2'h1;
  localparam logic [1:0] TERM_INVALID = 2'h2;
  localparam logic [1:0] TERM_READY   = 2'h3;

  // summary byte classes for floppy errors
  localparam logic [1:0] OP_FORMAT    = 2'h3;
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;
  localparam logic [3:0] SETUP_PREFIX = 4'h1;
  localparam logic [5:0] GEN_LOW_ZERO = 6'h00;
  localparam logic [7:0] GEN_CLEAR    = 8'h00;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;

  // hard-disk read attempts before a sector is declared bad
  localparam int unsigned ATTEMPT_W      = 4;
  localparam logic [ATTEMPT_W-1:0] RETRY_ATTEMPTS = 4'hA;
  localparam logic [ATTEMPT_W-1:0] ATTEMPT_ONE    = 4'h1;
  localparam logic [ATTEMPT_W-1:0] ATTEMPT_NONE   = 4'h0;

  typedef struct packed {
    logic [1:0] term;
    logic       seek_end;
    logic       fault;
    logic       not_ready;
    logic       head;
    logic [1:0] unit;
  } st0_type;

  typedef struct packed {
    logic end_of_track;
    logic zero6;
    logic crc;
    logic overrun;
    logic zero3;
    logic no_sector;
    logic write_prot;
    logic missing_am;
  } st1_type;

  typedef struct packed {
    logic zero7;
    logic deleted;
    logic crc;
    logic wrong_cyl;
    logic unused3;
    logic no_sector;
    logic bad_cyl;
    logic missing_dam;
  } st2_type;

  typedef struct packed {
    st0_type    st0;
    st1_type    st1;
    st2_type    st2;
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } fdc_result_type;

  typedef struct packed {
    logic       setup_err;
    logic [3:0] setup_code;
    logic [1:0] op;
  } fdc_general_type;

  typedef struct packed {
    logic bad_block;
    logic crc;
    logic unused5;
    logic id_missing;
    logic unused3;
    logic aborted;
    logic track_zero_missing;
    logic data_mark_missing;
  } hd_err_type;

  typedef struct packed {
    logic read_fail;
    logic crc_seen;
    logic read_ok;
    logic bad_id;
    logic id_missing;
    logic aborted;
    logic tz_missing;
    logic dam_absent;
  } hd_event_type;

  typedef struct packed {
    logic [2:0] unused;
    logic       busy;
    logic [3:0] seeking;
  } main_status_type;

  typedef enum logic [0:0] {CMD_FULL, CMD_SUMMARY} host_cmd_type;
  typedef enum logic [1:0] {TGT_FLOPPY, TGT_HARD, TGT_RAM} target_type;

endpackage

//--- src/disk_status_core.sv
// disk_status_core: result block, controller status and hard-disk error flags
// of the disk controller, read back by host status commands.
// assumes all inputs synchronous to mclk_in and event inputs one-cycle pulses.
//
// Summary of operation
// - at floppy transfer end capture seven result bytes, return them with the always-zero status bits forced to zero
// - byte order: status zero, one, two, cylinder, head, sector, size code
// - controller status: bits 0-3 drive seeking, bit 4 busy, 5-7 zero
// - status zero: unit select, head, not ready, track0/fault, seek end
// - status zero bits 7:6 give termination class
// - status one flag layout; bits 3 and 6 read zero
// - status two flag layout; bit 7 reads zero
// - hard-disk error register layout; bits 5 and 3 unused
// - in CRC mode a data-field CRC mismatch sets the CRC flag
// - with retries, ten attempts; read failures flag bad block only after all fail, a bad ID flags it at once
// - missing data mark after header read sets its flag
// - abandoned hard-disk command sets the aborted flag
// - RAM disk reports no error code
// - floppy summary byte: class in top bits, 0001 prefix for setup faults
`timescale 1ns/1ps
module disk_status_core (
  input  wire logic                              mclk_in,
  input  wire logic                              arst_n_in,
  input  wire logic                              disk_cmd_start_in,
  input  wire logic [3:0]                        drive_seeking_in,
  input  wire logic                              fdc_done_in,
  input  wire disk_status_pkg::fdc_result_type   fdc_result_in,
  input  wire disk_status_pkg::fdc_general_type  fdc_general_in,
  input  wire disk_status_pkg::hd_event_type     hd_event_in,
  input  wire logic                              crc_mode_in,
  input  wire logic                              retry_en_in,
  input  wire logic                              host_cmd_valid_in,
  input  wire disk_status_pkg::host_cmd_type     host_cmd_in,
  input  wire disk_status_pkg::target_type       host_target_in,
  input  wire logic                              host_take_in,
  output logic                                   host_cmd_ready_out,
  output logic [7:0]                             result_byte_out,
  output logic                                   result_valid_out,
  output logic                                   result_last_out,
  output disk_status_pkg::main_status_type       main_status_out,
  output disk_status_pkg::hd_err_type            hd_error_out,
  output logic                                   hd_retry_req_out
);
  import disk_status_pkg::*;

  typedef enum logic [0:0] {S_IDLE, S_SEND} stream_state_type;

  fdc_result_type              result_reg;
  logic [7:0]                  general_reg;
  hd_err_type                  hd_err_reg;
  logic [ATTEMPT_W-1:0]        attempts_reg;
  logic                        busy_reg;
  logic                        retry_reg;
  main_status_type             main_reg;
  stream_state_type            state_reg;
  logic [IDX_W-1:0]            idx_reg;
  logic [7:0]                  byte_reg;
  logic                        valid_reg;
  logic                        last_reg;
  logic                        cmd_take;
  logic                        byte_take;
  logic [ATTEMPT_W-1:0]        attempts_next;

  // picks one byte of the result block by its position
  function automatic logic [7:0] result_byte(input fdc_result_type r,
                                             input logic [IDX_W-1:0] i);
    logic [7:0] b;
    b = BYTE_ZERO;
    unique case (i)
      3'h0: b = r.st0;
      3'h1: b = r.st1;
      3'h2: b = r.st2;
      3'h3: b = r.cyl;
      3'h4: b = r.head;
      3'h5: b = r.sector;
      3'h6: b = r.size;
      default: b = BYTE_ZERO;
    endcase
    return b;
  endfunction

  // forces the always-zero bits of the status registers
  function automatic fdc_result_type clean_result(input fdc_result_type r);
    fdc_result_type c;
    c = r;
    c.st1.zero3 = 1'b0;
    c.st1.zero6 = 1'b0;
    c.st2.zero7 = 1'b0;
    return c;
  endfunction

  assign cmd_take           = host_cmd_valid_in && host_cmd_ready_out;
  assign byte_take          = valid_reg && host_take_in;
  assign host_cmd_ready_out = (state_reg == S_IDLE);
  assign attempts_next      = attempts_reg + ATTEMPT_ONE;

  // floppy result block: captured whole at transfer end, then frozen
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      result_reg <= '0;
    else if (fdc_done_in)
      result_reg <= clean_result(fdc_result_in);
  end

  // floppy summary byte; setup faults outrank transfer errors
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      general_reg <= GEN_CLEAR;
    else if (fdc_done_in)
    begin
      if (fdc_general_in.setup_err)
        general_reg <= {SETUP_PREFIX, fdc_general_in.setup_code};
      else if (fdc_result_in.st0.term != TERM_NORMAL)
        general_reg <= {fdc_general_in.op, GEN_LOW_ZERO};
      else
        general_reg <= GEN_CLEAR;
    end
  end

  // busy from command start to floppy completion; start wins a tie
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      busy_reg <= 1'b0;
    else if (disk_cmd_start_in)
      busy_reg <= 1'b1;
    else if (fdc_done_in)
      busy_reg <= 1'b0;
  end

  // controller status, registered so the host sees a clean byte
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      main_reg <= '0;
    else
    begin
      main_reg.seeking <= drive_seeking_in;
      main_reg.busy    <= busy_reg;
      main_reg.unused  <= '0;
    end
  end

  // read attempt counter; counts each failure, otherwise cleared at command start or good read
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      attempts_reg <= ATTEMPT_NONE;
    else if (hd_event_in.read_fail)
      attempts_reg <= attempts_next;
    else if (disk_cmd_start_in || hd_event_in.read_ok)
      attempts_reg <= ATTEMPT_NONE;
  end

  // retry request pulse while fewer than the full count have failed
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      retry_reg <= 1'b0;
    else
      retry_reg <= hd_event_in.read_fail && retry_en_in
                   && (attempts_next < RETRY_ATTEMPTS);
  end

  // hard-disk error flags: cleared at command start, but a flag raised in
  // that same cycle survives, so no event is lost at the boundary
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      hd_err_reg <= '0;
    else
    begin
      if (disk_cmd_start_in)
        hd_err_reg <= '0;
      if (hd_event_in.read_fail && hd_event_in.crc_seen && crc_mode_in)
        hd_err_reg.crc <= 1'b1;
      if (hd_event_in.bad_id || (hd_event_in.read_fail && retry_en_in
          && attempts_next >= RETRY_ATTEMPTS))
        hd_err_reg.bad_block <= 1'b1;
      if (hd_event_in.id_missing)
        hd_err_reg.id_missing <= 1'b1;
      if (hd_event_in.aborted)
        hd_err_reg.aborted <= 1'b1;
      if (hd_event_in.tz_missing)
        hd_err_reg.track_zero_missing <= 1'b1;
      if (hd_event_in.dam_absent)
        hd_err_reg.data_mark_missing <= 1'b1;
      hd_err_reg.unused5 <= 1'b0;
      hd_err_reg.unused3 <= 1'b0;
    end
  end

  // reply streamer: one byte stands until the host takes it
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_reg <= S_IDLE;
      idx_reg   <= IDX_FIRST;
      byte_reg  <= BYTE_ZERO;
      valid_reg <= 1'b0;
      last_reg  <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE:
          if (cmd_take)
          begin
            state_reg <= S_SEND;
            valid_reg <= 1'b1;
            idx_reg   <= IDX_FIRST;
            if (host_cmd_in == CMD_FULL)
            begin
              byte_reg <= result_byte(result_reg, IDX_FIRST);
              last_reg <= 1'b0;
            end
            else
            begin
              last_reg <= 1'b1;
              unique case (host_target_in)
                TGT_FLOPPY: byte_reg <= general_reg;
                TGT_HARD:   byte_reg <= hd_err_reg;
                default:    byte_reg <= BYTE_ZERO;
              endcase
            end
          end
        S_SEND:
          if (byte_take)
          begin
            if (last_reg)
            begin
              state_reg <= S_IDLE;
              valid_reg <= 1'b0;
              last_reg  <= 1'b0;
            end
            else
            begin
              idx_reg  <= idx_reg + 3'h1;
              byte_reg <= result_byte(result_reg, idx_reg + 3'h1);
              last_reg <= (idx_reg + 3'h1 == IDX_LAST);
            end
          end
      endcase
    end
  end

  assign result_byte_out  = byte_reg;
  assign result_valid_out = valid_reg;
  assign result_last_out  = last_reg;
  assign main_status_out  = main_reg;
  assign hd_error_out     = hd_err_reg;
  assign hd_retry_req_out = retry_reg;

  // checks

  sequence full_req;
    cmd_take && host_cmd_in == CMD_FULL;
  endsequence

  sequence ten_fails;
    hd_event_in.read_fail && retry_en_in && attempts_reg == 4'h9;
  endsequence

  AST_FULL_FIRST: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    full_req |=> valid_reg && byte_reg == $past(result_reg.st0) && !last_reg)
    else $error("full reply did not open with status zero");

  AST_LAST_SIZE: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    valid_reg && last_reg && idx_reg == IDX_LAST |-> byte_reg == result_reg.size)
    else $error("seventh byte is not the size code");

  AST_MAIN: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    ##1 main_status_out.seeking == $past(drive_seeking_in) && main_status_out.unused == 3'h0)
    else $error("controller status wrong");

  AST_ST0: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    fdc_done_in |=> result_reg.st0 == $past(fdc_result_in.st0))
    else $error("status zero not captured");

  AST_TERM: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    fdc_done_in && fdc_result_in.st0.term == TERM_INVALID |=> result_reg.st0.term == 2'h2)
    else $error("termination class lost");

  AST_ZERO_BITS: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    !result_reg.st1.zero3 && !result_reg.st1.zero6 && !result_reg.st2.zero7)
    else $error("reserved status bit set");

  AST_HD_UNUSED: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    hd_event_in.aborted |=> hd_error_out[2] && !hd_error_out[5] && !hd_error_out[3])
    else $error("error register layout wrong");

  AST_CRC: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    hd_event_in.read_fail && hd_event_in.crc_seen && crc_mode_in |=> hd_error_out.crc)
    else $error("crc flag not set");

  AST_BBD_LATE: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    $rose(hd_err_reg.bad_block) && !$past(hd_event_in.bad_id) |-> $past(attempts_reg) == 4'h9)
    else $error("bad block set before ten failures");

  AST_BBD_TENTH: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    ten_fails |=> hd_err_reg.bad_block && !hd_retry_req_out)
    else $error("bad block missing after tenth failure");

  AST_DM: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    hd_event_in.dam_absent |=> hd_err_reg.data_mark_missing)
    else $error("data mark flag not set");

  AST_RAM: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    cmd_take && host_cmd_in == CMD_SUMMARY && host_target_in == TGT_RAM
    |=> byte_reg == 8'h00 && last_reg)
    else $error("ram disk reported an error code");

  AST_HOLD: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    !fdc_done_in |=> $stable(result_reg))
    else $error("result block changed without a new result");

endmodule // disk_status_core

//--- sim/host_model.sv
// host_model: host side of the status command handshake and byte read-back.
// assumes one clock; tb calls run_cmd just after a rising edge.
`timescale 1ns/1ps
module host_model
  import disk_status_pkg::*;
(
  input  wire logic                          mclk_in,
  input  wire logic                          host_cmd_ready_in,
  input  wire logic [7:0]                    result_byte_in,
  input  wire logic                          result_valid_in,
  input  wire logic                          result_last_in,
  output disk_status_pkg::host_cmd_type      host_cmd_out,
  output disk_status_pkg::target_type        host_target_out,
  output logic                               host_cmd_valid_out,
  output logic                               host_take_out
);
  logic [7:0] got [0:7];
  logic [7:0] last_bits;
  logic [7:0] n_got;
  logic [7:0] ready_seen;

  // idle levels at time zero
  initial
  begin
    host_cmd_out       = CMD_FULL;
    host_target_out    = TGT_FLOPPY;
    host_cmd_valid_out = 1'b0;
    host_take_out      = 1'b0;
  end

  // request held until an edge sees ready; stall delays each take
  task automatic run_cmd(input host_cmd_type c, input target_type t, input int stall);
    int wait_n;
    int guard;
    wait_n = 0;
    guard = 0;
    n_got = 8'h00;
    last_bits = 8'h00;
    ready_seen = 8'h00;
    host_cmd_out = c;
    host_target_out = t;
    host_cmd_valid_out = 1'b1;
    while (host_cmd_ready_in !== 1'b1 && guard < 50)
    begin
      @(posedge mclk_in);
      #1;
      guard++;
    end
    @(posedge mclk_in);
    #1;
    host_cmd_valid_out = 1'b0;
    host_cmd_out = host_cmd_type'(~c);
    // ready must stay low while bytes are streaming
    while (last_bits == 8'h00 && guard < 100)
    begin
      if (host_cmd_ready_in === 1'b1)
        ready_seen++;
      if (result_valid_in === 1'b1 && wait_n >= stall)
      begin
        got[n_got[2:0]] = result_byte_in;
        last_bits[n_got[2:0]] = result_last_in;
        n_got++;
        host_take_out = 1'b1;
        wait_n = 0;
      end
      else
      begin
        host_take_out = 1'b0;
        wait_n++;
      end
      @(posedge mclk_in);
      #1;
      guard++;
    end
    host_take_out = 1'b0;
  endtask
endmodule // host_model

//--- sim/tb.sv
// tb: self-checking bench for disk_status_core.
// assumes host_model as the host; disk engine inputs driven here.
`timescale 1ns/1ps
module tb;
  import disk_status_pkg::*;
  logic            mclk, arst_n, cmd_start, fdc_done, crc_mode, retry_en;
  logic [3:0]      seeking;
  fdc_result_type  fdc_res;
  fdc_general_type fdc_gen;
  hd_event_type    hd_ev;
  host_cmd_type    h_cmd;
  target_type      h_tgt;
  logic            h_valid, h_take, h_ready, r_valid, r_last, retry_req;
  logic [7:0]      r_byte;
  main_status_type main_status;
  hd_err_type      hd_error;
  int              error_cnt = 0;
  int              num_checks = 0;
  logic [7:0]      exp_b [0:6] = '{8'h00, 8'hB7, 8'h7F, 8'h20, 8'h01, 8'h0B, 8'h02};
  logic [7:0]      ev_tbl [0:5] = '{8'h08, 8'h02, 8'h01, 8'hC0, 8'h10, 8'h04};
  logic [7:0]      err_tbl [0:5] = '{8'h10, 8'h02, 8'h01, 8'h40, 8'h80, 8'h04};

  always #2 mclk = ~mclk;

  disk_status_core dut_u (
    .mclk_in(mclk), .arst_n_in(arst_n), .disk_cmd_start_in(cmd_start),
    .drive_seeking_in(seeking), .fdc_done_in(fdc_done), .fdc_result_in(fdc_res),
    .fdc_general_in(fdc_gen), .hd_event_in(hd_ev), .crc_mode_in(crc_mode),
    .retry_en_in(retry_en), .host_cmd_valid_in(h_valid), .host_cmd_in(h_cmd),
    .host_target_in(h_tgt), .host_take_in(h_take), .host_cmd_ready_out(h_ready),
    .result_byte_out(r_byte), .result_valid_out(r_valid), .result_last_out(r_last),
    .main_status_out(main_status), .hd_error_out(hd_error), .hd_retry_req_out(retry_req)
  );

  host_model host_u (
    .mclk_in(mclk), .host_cmd_ready_in(h_ready), .result_byte_in(r_byte),
    .result_valid_in(r_valid), .result_last_in(r_last), .host_cmd_out(h_cmd),
    .host_target_out(h_tgt), .host_cmd_valid_out(h_valid), .host_take_out(h_take)
  );

  // shared helpers: one edge plus drive delay, compare, pulses
  task tick;
    @(posedge mclk);
    #1;
  endtask

  task check(input string name, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", name, e, g);
      error_cnt++;
    end
  endtask

  task pulse_start;
    cmd_start = 1'b1;
    tick;
    cmd_start = 1'b0;
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("[FAIL] watchdog expected done seen hang");
    give_verdict;
  end

  // main sequence
  initial
  begin
    mclk = 1'b0; arst_n = 1'b0; cmd_start = 1'b0; fdc_done = 1'b0;
    crc_mode = 1'b0; retry_en = 1'b0; seeking = 4'h0;
    fdc_res = '0; fdc_gen = '0; hd_ev = '0;
    repeat (5) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    tick;
    seeking = 4'h5;
    pulse_start;
    tick;
    check("main_status_busy", 8'h15, main_status);
    // every termination class, every op class; inputs change after capture
    for (int k = 0; k < 4; k++)
    begin
      exp_b[0] = {k[1:0], 6'h2D};
      fdc_res = {k[1:0], 6'h2D, 8'hFF, 8'hFF, 8'h20, 8'h01, 8'h0B, 8'h02};
      fdc_gen = {1'b0, 4'h0, k[1:0]};
      fdc_done = 1'b1;
      tick;
      fdc_done = 1'b0;
      fdc_res = {8'h00, 48'h5A5A5A5A5A5A};
      fdc_gen = {1'b1, 4'hF, 2'h0};
      host_u.run_cmd(CMD_FULL, TGT_FLOPPY, k);
      for (int i = 0; i < 7; i++)
        check("full_byte", exp_b[i], host_u.got[i]);
      check("last_flags", 8'h40, host_u.last_bits);
      check("byte_count", 8'h07, host_u.n_got);
      check("ready_streaming", 8'h00, host_u.ready_seen);
      host_u.run_cmd(CMD_SUMMARY, TGT_FLOPPY, 0);
      check("summary", (k == 0) ? 8'h00 : {k[1:0], 6'h00}, host_u.got[0]);
    end
    check("main_status_idle", 8'h05, main_status);
    // setup failure code and ram disk summary
    fdc_gen = {1'b1, 4'h3, 2'h2};
    fdc_done = 1'b1;
    tick;
    fdc_done = 1'b0;
    host_u.run_cmd(CMD_SUMMARY, TGT_FLOPPY, 1);
    check("setup_summary", 8'h13, host_u.got[0]);
    host_u.run_cmd(CMD_SUMMARY, TGT_RAM, 0);
    check("ram_summary", 8'h00, host_u.got[0]);
    // a data crc failure outside crc mode must leave the flag clear
    pulse_start;
    hd_ev = 8'hC0;
    tick;
    hd_ev = '0;
    check("crc_mode_off", 8'h00, hd_error);
    // hard-disk flags one at a time, each after a fresh command
    crc_mode = 1'b1;
    for (int j = 0; j < 6; j++)
    begin
      pulse_start;
      hd_ev = ev_tbl[j];
      tick;
      hd_ev = '0;
      check("hd_flag", err_tbl[j], hd_error);
    end
    host_u.run_cmd(CMD_SUMMARY, TGT_HARD, 0);
    check("hd_summary", 8'h04, host_u.got[0]);
    // ten failing reads with and without retries
    for (int r = 1; r >= 0; r--)
    begin
      retry_en = r[0];
      pulse_start;
      check("hd_cleared", 8'h00, hd_error);
      for (int a = 1; a <= 10; a++)
      begin
        hd_ev = 8'h80;
        tick;
        hd_ev = '0;
        check("retry_req", {7'h00, (r == 1 && a < 10)}, {7'h00, retry_req});
        if (a == 9)
          check("bad_block_early", 8'h00, hd_error);
        tick;
      end
      check("bad_block", (r == 1) ? 8'h80 : 8'h00, hd_error);
    end
    // a good read after nine failures restarts the attempt count
    retry_en = 1'b1;
    pulse_start;
    for (int a = 1; a <= 11; a++)
    begin
      hd_ev = (a == 10) ? 8'h20 : 8'h80;
      tick;
      hd_ev = '0;
    end
    check("retry_after_ok", 8'h01, {7'h00, retry_req});
    tick;
    check("bad_block_after_ok", 8'h00, hd_error);
    give_verdict;
  end
endmodule // tb
